/* hdl/sar_adc_map.svh */
// Register offsets, field positions, reset values and timing counts of the converter.
// Assumes inclusion by every design file that needs these values; the package does not include it.
`ifndef SAR_ADC_MAP_SVH
`define SAR_ADC_MAP_SVH

// Register indices; byte address is four times the index
`define CSR_INDEX        8'h70
`define RES_HI_INDEX     8'h71
`define RES_LO_INDEX     8'h72
`define EV_STAT_INDEX    8'h73
`define EV_MASK_INDEX    8'h74
`define CSR_ADDR         ({2'b00, `CSR_INDEX, 2'b00})
`define RES_HI_ADDR      ({2'b00, `RES_HI_INDEX, 2'b00})
`define RES_LO_ADDR      ({2'b00, `RES_LO_INDEX, 2'b00})
`define EV_STAT_ADDR     ({2'b00, `EV_STAT_INDEX, 2'b00})
`define EV_MASK_ADDR     ({2'b00, `EV_MASK_INDEX, 2'b00})

// Control/status field positions
`define CSR_EOC_BIT      7
`define CSR_SPEED_BIT    6
`define CSR_ON_BIT       5
`define CSR_CH_MSB       3

// Reset values
`define CSR_RESET        8'h00
`define RES_RESET        10'h000

// Conversion timing in conversion clock ticks, divider end count in pclk cycles, trial and result codes
`define CONV_CYCLES      5'd14
`define FIRST_TRIAL      5'd2
`define LAST_TRIAL       5'd11
`define TRIAL_MSB        10'h200
`define RESULT_FULL      10'h3FF
`define RESULT_ZERO      10'h000
`define DIV4_LAST        2'h3

`endif

/* hdl/sar_adc_pkg.sv */
// Types shared by the converter control and its conversion engine.
// Assumes the map header sits beside it in hdl/.
package sar_adc_pkg;

    // Engine phase
    typedef enum logic [1:0] {
        PH_IDLE   = 2'b00,
        PH_SAMPLE = 2'b01,
        PH_TRIAL  = 2'b10
    } phase_t;

    // Whole state of the conversion engine
    typedef struct packed {
        phase_t      phase;
        logic [1:0]  div;
        logic [4:0]  cnt;
        logic [9:0]  code;
        logic [9:0]  result;
        logic        done;
    } engine_state_t;

    // Whole state of the register side
    typedef struct packed {
        logic        speed;
        logic        on;
        logic [3:0]  ch;
        logic        eoc;
        logic [7:0]  res_hi;
        logic [1:0]  res_lo;
        logic        ev_stat;
        logic        ev_mask;
        logic        pwr;
        logic        irq;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } ctrl_state_t;

endpackage

/* hdl/sar_engine.sv */
// Successive approximation sequencer with its conversion clock divider.
// Assumes a comparator that reports input at or above the trial code on cmp_high,
// and reference detectors valid while a conversion runs.
`include "sar_adc_map.svh"

module sar_engine (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       run,
    input  wire logic       restart,
    input  wire logic       speed,
    input  wire logic       cmp_high,
    input  wire logic       above_ref,
    input  wire logic       below_ref,
    output logic [9:0]      trial_code,
    output logic [9:0]      result,
    output logic            sample_hold,
    output logic            done
);

    sar_adc_pkg::engine_state_t s_ff;
    sar_adc_pkg::engine_state_t nxt_s;
    logic                       tick;
    logic [4:0]                 newcnt;
    logic [3:0]                 idx;

    // Next state of the sequencer
    always_comb begin
        nxt_s      = s_ff;
        nxt_s.done = 1'b0;
        nxt_s.div  = s_ff.div + 2'd1;
        // [R13] Divide by two or four
        tick   = speed ? s_ff.div[0] : (s_ff.div == `DIV4_LAST);
        newcnt = s_ff.cnt + 5'd1;
        idx    = 4'(`LAST_TRIAL - newcnt);
        if (!run) begin
            nxt_s.phase = sar_adc_pkg::PH_IDLE;
            nxt_s.cnt   = 5'd0;
            nxt_s.div   = 2'd0;
            nxt_s.code  = `RESULT_ZERO;
        end else if (restart || s_ff.phase == sar_adc_pkg::PH_IDLE) begin
            // [R3] Start on enable or restart
            nxt_s.phase = sar_adc_pkg::PH_SAMPLE;
            nxt_s.cnt   = 5'd0;
            nxt_s.div   = 2'd0;
            nxt_s.code  = `TRIAL_MSB;
        end else if (tick) begin
            nxt_s.cnt   = newcnt;
            nxt_s.phase = sar_adc_pkg::PH_TRIAL;
            // One bit decided per tick on ticks 2 to 11, MSB first
            if (newcnt >= `FIRST_TRIAL && newcnt <= `LAST_TRIAL) begin
                if (!cmp_high) begin
                    nxt_s.code[idx] = 1'b0;
                end
                if (idx != 4'd0) begin
                    nxt_s.code[idx - 4'd1] = 1'b1;
                end
            end
            // [R18] Done after the set tick count
            if (newcnt == `CONV_CYCLES) begin
                nxt_s.done = 1'b1;
                // [R1] Saturate above high reference
                if (above_ref) begin
                    nxt_s.result = `RESULT_FULL;
                // [R2] Zero below low reference
                end else if (below_ref) begin
                    nxt_s.result = `RESULT_ZERO;
                end else begin
                    nxt_s.result = nxt_s.code;
                end
                // [R3] Next conversion follows at once
                nxt_s.phase = sar_adc_pkg::PH_SAMPLE;
                nxt_s.cnt   = 5'd0;
                nxt_s.code  = `TRIAL_MSB;
            end
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign trial_code  = s_ff.code;
    assign result      = s_ff.result;
    assign sample_hold = (s_ff.phase == sar_adc_pkg::PH_SAMPLE);
    assign done        = s_ff.done;

endmodule

/* hdl/sar_adc_control.sv */
// APB register side of the 10-bit converter: control/status, result bytes, event flag.
// Assumes an APB master on pclk and an analog front end driven by the engine outputs.
//
// How it works
// [R1] Input above high reference reads as high byte FFh, low bits 03h.
// [R2] Input below low reference reads as zero in both result registers.
// [R3] Setting converter_on starts conversions that repeat back to back.
// [R4] Each finished conversion sets the done flag and loads the results; the code drops a completion that meets a channel change in the same cycle.
// [R5] Done flag clears on high byte read or any control write.
// [R6] Software reads low bits then high byte for ten bits.
// [R7] Software reads only the high byte for eight bits.
// [R8] Results are not held; next conversion overwrites both registers.
// [R9] Changing channel_select restarts conversion and clears the done flag.
// [R10] Clearing converter_on stops conversion and powers the converter down.
// [R11] Wait mode leaves the converter running unchanged.
// [R12] Halt disables the converter; software waits stabilization after wake-up.
// [R13] Speed bit selects conversion clock of pclk over four or two.
// [R14] Four-bit channel_select picks analog input of that number.
// [R15] Software writes zero to reserved bit four.
// [R16] High byte holds result bits nine down to two.
// [R17] Low register holds result bits one and zero, rest zero.
// [R18] Done asserts only after the set count of conversion ticks.
`include "sar_adc_map.svh"

module sar_adc_control (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    input  wire logic        halt_mode,
    input  wire logic        cmp_high,
    input  wire logic        above_ref,
    input  wire logic        below_ref,
    output logic [3:0]       channel_select,
    output logic             converter_on,
    output logic             sample_hold,
    output logic [9:0]       trial_code
);

    sar_adc_pkg::ctrl_state_t s_ff;
    sar_adc_pkg::ctrl_state_t nxt_s;

    logic       run;
    logic       restart;
    logic       conv_done;
    logic [9:0] conv_result;
    logic       setup_wait;
    logic       access;
    logic       wr;
    logic       rd;
    logic       csr_wr;
    logic       ch_change;
    logic       mapped;
    logic [7:0] read_byte;

    // [R12] Halt gates the converter off
    // [R11] Wait mode has no input here
    assign run = s_ff.on && !halt_mode;

    // Conversion sequencer
    sar_engine u_engine (
        .pclk        (pclk),
        .presetn     (presetn),
        .run         (run),
        .restart     (restart),
        .speed       (s_ff.speed),
        .cmp_high    (cmp_high),
        .above_ref   (above_ref),
        .below_ref   (below_ref),
        .trial_code  (trial_code),
        .result      (conv_result),
        .sample_hold (sample_hold),
        .done        (conv_done)
    );

    // Bus phase decode
    assign setup_wait = psel && penable && !s_ff.pready;
    assign access     = psel && penable && s_ff.pready;
    assign wr         = access && pwrite;
    assign rd         = access && !pwrite;
    assign csr_wr     = wr && (paddr == `CSR_ADDR);
    // [R9] Channel change restarts
    assign ch_change  = csr_wr && (pwdata[`CSR_CH_MSB:0] != s_ff.ch);
    assign restart    = ch_change;

    // Address map and read mux
    always_comb begin
        mapped    = 1'b1;
        read_byte = 8'h00;
        case (paddr)
            `CSR_ADDR: begin
                // Reserved bit four reads zero
                read_byte = {s_ff.eoc, s_ff.speed, s_ff.on, 1'b0, s_ff.ch};
            end
            `RES_HI_ADDR: begin
                read_byte = s_ff.res_hi;
            end
            `RES_LO_ADDR: begin
                // [R17] Upper bits forced zero
                read_byte = {6'h00, s_ff.res_lo};
            end
            `EV_STAT_ADDR: begin
                read_byte = {7'h00, s_ff.ev_stat};
            end
            `EV_MASK_ADDR: begin
                read_byte = {7'h00, s_ff.ev_mask};
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    // Next state of the register side
    always_comb begin
        nxt_s = s_ff;

        // One wait state, then answer
        nxt_s.pready  = setup_wait;
        nxt_s.pslverr = setup_wait && !mapped;
        if (setup_wait) begin
            nxt_s.prdata = {24'h0000_00, read_byte};
        end

        // Control fields; reserved bit is dropped
        if (csr_wr) begin
            nxt_s.speed = pwdata[`CSR_SPEED_BIT];
            nxt_s.on    = pwdata[`CSR_ON_BIT];
            // [R14] Channel number drives the mux
            nxt_s.ch    = pwdata[`CSR_CH_MSB:0];
        end
        if (wr && paddr == `EV_MASK_ADDR) begin
            nxt_s.ev_mask = pwdata[0];
        end

        // [R5] Done cleared by control write or high read
        if (csr_wr || (rd && paddr == `RES_HI_ADDR)) begin
            nxt_s.eoc = 1'b0;
        end
        // Event flag cleared by reading it
        if (rd && paddr == `EV_STAT_ADDR) begin
            nxt_s.ev_stat = 1'b0;
        end

        // Completion wins over any clear but a channel change in the same cycle
        // [R9] Restart drops a completion on its edge
        if (conv_done && !restart) begin
            // [R4] Flag and results on completion
            nxt_s.eoc     = 1'b1;
            nxt_s.ev_stat = 1'b1;
            // [R8] Overwrite, nothing held back
            // [R16] Upper eight result bits
            nxt_s.res_hi  = conv_result[9:2];
            nxt_s.res_lo  = conv_result[1:0];
        end

        // [R10] Power follows enable
        nxt_s.pwr = nxt_s.on && !halt_mode;
        nxt_s.irq = nxt_s.ev_stat && nxt_s.ev_mask;
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_ff       <= '0;
            s_ff.res_hi <= 8'(`RES_RESET >> 2);
        end else begin
            s_ff <= nxt_s;
        end
    end

    // Outputs straight from the state register
    assign prdata         = s_ff.prdata;
    assign pready         = s_ff.pready;
    assign pslverr        = s_ff.pslverr;
    assign irq            = s_ff.irq;
    assign channel_select = s_ff.ch;
    assign converter_on   = s_ff.pwr;

    // Checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // [R4] Flag follows completion
    a_done_sets_flag: assert property (conv_done && !restart |=> s_ff.eoc) // [R4]
        else $error("done flag not set after conversion");

    // [R16] High byte tracks the result
    a_high_byte_load: assert property ( // [R16]
        conv_done && !restart |=> s_ff.res_hi == $past(conv_result[9:2]))
        else $error("high byte not loaded from result");

    // [R17] Low bits track the result
    a_low_bits_load: assert property ( // [R17]
        conv_done && !restart |=> s_ff.res_lo == $past(conv_result[1:0]))
        else $error("low bits not loaded from result");

    // [R17] Low register upper bits
    a_low_upper_zero: assert property ( // [R17]
        pready && !pwrite && paddr == `RES_LO_ADDR |-> prdata[31:2] == 30'h0)
        else $error("low result register upper bits not zero");

    // [R17] Low read returns the stored bits
    a_low_read_data: assert property ( // [R17]
        pready && !pwrite && paddr == `RES_LO_ADDR |-> prdata[1:0] == $past(s_ff.res_lo))
        else $error("low bits read returned wrong data");

    // [R16] High read returns the stored byte
    a_high_read_data: assert property ( // [R16]
        pready && !pwrite && paddr == `RES_HI_ADDR |-> prdata[7:0] == $past(s_ff.res_hi))
        else $error("high byte read returned wrong data");

    // [R4] Status read shows the flag, reserved bit zero
    a_csr_read_data: assert property ( // [R4]
        pready && !pwrite && paddr == `CSR_ADDR
        |-> prdata[7] == $past(s_ff.eoc) && !prdata[4])
        else $error("status read returned wrong flag");

    // [R4] Flag rises only on completion
    a_flag_source: assert property ( // [R4]
        !s_ff.eoc ##1 s_ff.eoc |-> $past(conv_done))
        else $error("done flag set without a completion");

    // [R8] Results change only on completion
    a_results_held: assert property ( // [R8]
        (!conv_done || restart) |=> $stable(s_ff.res_hi) && $stable(s_ff.res_lo))
        else $error("results changed without a completion");

    // [R5] High read clears flag
    a_high_read_clr: assert property ( // [R5]
        rd && paddr == `RES_HI_ADDR && !conv_done |=> !s_ff.eoc)
        else $error("high byte read left done flag set");

    // [R5] Control write clears flag
    a_csr_write_clr: assert property (csr_wr && !conv_done |=> !s_ff.eoc) // [R5]
        else $error("control write left done flag set");

    // [R5] Low read keeps flag
    a_low_read_keep: assert property ( // [R5]
        rd && paddr == `RES_LO_ADDR && s_ff.eoc |=> s_ff.eoc)
        else $error("low read cleared done flag");

    // [R14] Channel field taken from the write
    a_chan_field: assert property ( // [R14]
        csr_wr |=> channel_select == $past(pwdata[`CSR_CH_MSB:0]))
        else $error("channel select not taken from write");

    // [R13] Speed bit taken from the write
    a_speed_field: assert property ( // [R13]
        csr_wr |=> s_ff.speed == $past(pwdata[`CSR_SPEED_BIT]))
        else $error("speed bit not taken from write");

    // [R3] Enable bit taken from the write
    a_on_field: assert property ( // [R3]
        csr_wr |=> s_ff.on == $past(pwdata[`CSR_ON_BIT]))
        else $error("enable bit not taken from write");

    // [R3] Enabling starts sampling at the top trial code
    a_start_sample: assert property ( // [R3]
        !run ##1 run |=> sample_hold && trial_code == `TRIAL_MSB)
        else $error("enable did not start a conversion");

    // [R9] New channel restarts sampling
    a_chan_restart: assert property ( // [R9]
        ch_change && run |=> sample_hold && !conv_done)
        else $error("channel change did not restart conversion");

    // [R10] Off means no sampling and no power
    a_off_stops: assert property ( // [R10]
        !s_ff.on ##1 !s_ff.on |-> !sample_hold && !converter_on)
        else $error("converter active while switched off");

    // [R10] No completion while stopped
    a_off_no_done: assert property ( // [R10]
        !run |=> !conv_done)
        else $error("completion while converter stopped");

    // [R10] Power follows the enable bit
    a_power_follows: assert property ( // [R10]
        s_ff.on && !halt_mode && !csr_wr |=> converter_on)
        else $error("converter unpowered while enabled");

    // [R12] Halt drops power next cycle
    a_halt_power: assert property (halt_mode |=> !converter_on) // [R12]
        else $error("converter powered during halt");

    // [R18] No completion soon after a restart
    a_min_conv_time: assert property ( // [R18]
        restart |=> !conv_done [*8])
        else $error("conversion finished too early");

    // Bus answers after one wait state
    a_bus_wait: assert property (psel && !penable |=> !pready)
        else $error("answer given in setup cycle");

    // Answer lasts a single cycle
    a_ready_pulse: assert property (
        pready |=> !pready)
        else $error("ready held for more than one cycle");

    // Unmapped word answers with an error
    a_unmapped_err: assert property (
        setup_wait && !mapped |=> pready && pslverr)
        else $error("unmapped access answered without error");

    // Mapped word answers cleanly
    a_mapped_ok: assert property (
        setup_wait && mapped |=> pready && !pslverr)
        else $error("mapped access answered with error");

    // Error answer carries no data
    a_unmapped_zero: assert property (
        pready && pslverr |-> prdata == 32'h0000_0000)
        else $error("error answer carried data");

    // Registers occupy the low byte only
    a_prdata_upper: assert property (
        pready |-> prdata[31:8] == 24'h0000_00)
        else $error("read data above the low byte");

    // Mask bit taken from the write
    a_mask_field: assert property (
        wr && paddr == `EV_MASK_ADDR |=> s_ff.ev_mask == $past(pwdata[0]))
        else $error("mask bit not taken from write");

    // Event read clears the interrupt
    a_event_clear: assert property (
        rd && paddr == `EV_STAT_ADDR && !conv_done |=> !irq)
        else $error("event read left interrupt raised");

    c_conversion: cover property (conv_done ##[1:100] rd && paddr == `RES_HI_ADDR);
    c_channel: cover property (ch_change ##[1:200] conv_done);
    c_irq: cover property (!irq ##1 irq);
    c_unmapped: cover property (pready && pslverr);
    c_saturated: cover property (conv_done && conv_result == `RESULT_FULL);

endmodule

/* bench/analog_front.sv */
// Model of the analog side: per-input levels, sample and hold, comparator, ref detectors.
// Assumes the converter drives channel_select, sample_hold and trial_code on pclk.
module analog_front (
    input  wire logic       pclk,
    input  wire logic [3:0] channel_select,
    input  wire logic       converter_on,
    input  wire logic       sample_hold,
    input  wire logic [9:0] trial_code,
    output logic            cmp_high,
    output logic            above_ref,
    output logic            below_ref
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] level [16];
    logic [1:0] sat   [16];
    logic [9:0] held     = 10'h000;
    logic [1:0] held_sat = 2'b00;
    logic       junk     = 1'b0;

    always @(posedge pclk) begin
        junk <= ~junk;
        if (sample_hold) begin
            held     <= level[channel_select];
            held_sat <= sat[channel_select];
        end
    end

    always_comb begin
        cmp_high  = converter_on ? (held >= trial_code) : junk;
        above_ref = converter_on ? held_sat[1] : junk;
        below_ref = converter_on ? held_sat[0] : ~junk;
    end
endmodule

/* bench/tb.sv */
// Self-checking bench: APB traffic, random conversions, saturation, halt, stop, event flag.
// Assumes the design in hdl/ and the analog_front model beside this file.
`include "sar_adc_map.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk      = 1'b0;
    logic        presetn   = 1'b0;
    logic        psel      = 1'b0;
    logic        penable   = 1'b0;
    logic        pwrite    = 1'b0;
    logic        halt_mode = 1'b0;
    logic [11:0] paddr     = 12'h000;
    logic [31:0] pwdata    = 32'h0000_0000;
    logic [31:0] prdata, rdat;
    logic [9:0]  trial_code, lvl;
    logic [3:0]  channel_select, ch;
    logic [1:0]  sat;
    logic        pready, pslverr, irq, cmp_high, above_ref, below_ref;
    logic        converter_on, sample_hold, rerr, sh_q, sp;
    logic [11:0] regs [5] = '{`CSR_ADDR, `RES_HI_ADDR, `RES_LO_ADDR, `EV_STAT_ADDR,
                              `EV_MASK_ADDR};
    integer      seed = 32'h0ee6_6ef3;
    int          n_mismatch = 0, n_checks = 0, cyc = 0, rise = 0, period = 0;
    int          nt = `CONV_CYCLES;

    // Clock of 40 ns
    always #20 pclk = ~pclk;

    // Spacing of sample phase starts
    always @(posedge pclk) begin
        cyc++;
        if (sample_hold === 1'b1 && sh_q !== 1'b1) begin
            period = cyc - rise;
            rise = cyc;
        end
        sh_q = sample_hold;
    end

    sar_adc_control dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .halt_mode(halt_mode), .cmp_high(cmp_high),
        .above_ref(above_ref), .below_ref(below_ref), .channel_select(channel_select),
        .converter_on(converter_on), .sample_hold(sample_hold), .trial_code(trial_code));

    analog_front fe (.pclk(pclk), .channel_select(channel_select),
        .converter_on(converter_on), .sample_hold(sample_hold), .trial_code(trial_code),
        .cmp_high(cmp_high), .above_ref(above_ref), .below_ref(below_ref));

    function automatic logic [9:0] expect_code(input logic [9:0] v, input logic [1:0] s);
        return s[1] ? 10'h3ff : (s[0] ? 10'h000 : v);
    endfunction

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic fail();
        n_mismatch++;
        test_done();
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer, held until pready
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k == 20)
            fail();
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_eoc();
        int k;
        k = 0;
        do begin
            apb(1'b0, `CSR_ADDR, 32'h0);
            k++;
        end while (rdat[7] !== 1'b1 && k < 100);
        if (rdat[7] !== 1'b1)
            fail();
    endtask

    // Conversion on a new channel, low bits then high byte
    task automatic convert();
        logic [9:0] c;
        c = expect_code(lvl, sat);
        fe.level[ch] = lvl;
        fe.sat[ch] = sat;
        apb(1'b1, `CSR_ADDR, {24'h0, 1'b0, sp, 1'b1, 1'b0, ch});
        apb(1'b0, `CSR_ADDR, 32'h0);
        check(rdat, {24'h0, 1'b0, sp, 2'b10, ch});
        check({28'h0, channel_select}, {28'h0, ch});
        wait_eoc();
        apb(1'b0, `RES_LO_ADDR, 32'h0);
        check(rdat, {30'h0, c[1:0]});
        apb(1'b0, `CSR_ADDR, 32'h0);
        check({31'h0, rdat[7]}, 32'h1);
        apb(1'b0, `RES_HI_ADDR, 32'h0);
        check(rdat, {24'h0, c[9:2]});
        apb(1'b0, `CSR_ADDR, 32'h0);
        check({31'h0, rdat[7]}, 32'h0);
        wait_eoc();
        check({31'h0, period == nt * (sp ? 2 : 4)}, 32'h1);
    endtask

    initial begin
        for (int i = 0; i < 16; i++) begin
            fe.level[i] = 10'h000;
            fe.sat[i] = 2'b00;
        end
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values, then an unmapped word
        foreach (regs[i]) begin
            apb(1'b0, regs[i], 32'h0);
            check(rdat, 32'h0);
        end
        apb(1'b0, 12'h000, 32'h0);
        check({rdat[30:0], rerr}, 32'h1);
        // Random levels, saturation corners, both speeds
        ch = 4'h0;
        for (int i = 0; i < 6; i++) begin
            ch = (i == 0) ? 4'hf : (i == 1) ? 4'h0 : ch + 4'h1 + 4'($unsigned($random(seed)) % 15);
            lvl = 10'($random(seed));
            sat = (i == 0) ? 2'b10 : (i == 1) ? 2'b01 : 2'b00;
            sp = 1'(i);
            convert();
            check({31'h0, irq}, 32'h0);
        end
        // Halt powers down, completions stop, resume after
        halt_mode <= 1'b1;
        repeat (3) @(posedge pclk);
        apb(1'b0, `RES_HI_ADDR, 32'h0);
        check({31'h0, converter_on}, 32'h0);
        repeat (150) @(posedge pclk);
        apb(1'b0, `CSR_ADDR, 32'h0);
        check({31'h0, rdat[7]}, 32'h0);
        halt_mode <= 1'b0;
        wait_eoc();
        // Converter off stops conversion
        apb(1'b1, `CSR_ADDR, {28'h0, ch});
        repeat (150) @(posedge pclk);
        check({30'h0, converter_on, sample_hold}, 32'h0);
        apb(1'b0, `CSR_ADDR, 32'h0);
        check(rdat, {28'h0, ch});
        // Sticky event flag with mask
        apb(1'b1, `EV_MASK_ADDR, 32'h1);
        repeat (2) @(posedge pclk);
        check({31'h0, irq}, 32'h1);
        apb(1'b0, `EV_STAT_ADDR, 32'h1);
        check(rdat, 32'h1);
        repeat (3) @(posedge pclk);
        check({31'h0, irq}, 32'h0);
        test_done();
    end
endmodule
